//--- spg_pkg.sv
package spg_pkg;

  // ***********************************************************
  // Register map (APB byte addresses, one aligned word each)
  // ***********************************************************
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h00;
  localparam logic [7:0] ADDR_STACK_MID   = 8'h04;
  localparam logic [7:0] ADDR_STACK_BOT   = 8'h08;
  localparam logic [7:0] ADDR_PAGE_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;

  // ***********************************************************
  // Fields, reset values and page constants
  // ***********************************************************
  localparam int         AUTO_EN_BIT   = 0;
  localparam logic       AUTO_EN_RESET = 1'b1;
  localparam logic [7:0] PAGE_RESET    = 8'h00;
  localparam logic [7:0] PAGE_ZERO     = 8'h00;
  localparam logic [7:0] PAGE_FIFTEEN  = 8'h0f;
  localparam logic [7:0] UPPER_HALF    = 8'h80;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam int         ST_UPPER_BIT  = 0;
  localparam int         ST_POP_BIT    = 1;
  localparam int         ST_PUSH_BIT   = 2;
  localparam int         ST_POP_EMPTY_BIT = 3;

  // Stack contents travel together
  typedef struct packed {
    logic [7:0] top;
    logic [7:0] mid;
    logic [7:0] bot;
  } spg_stack_type;

  // Core's direct access request
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } spg_direct_type;

  // Decoded destination of a direct access
  typedef struct packed {
    logic       ram;
    logic       special_function_register;
    logic       all_pages;
    logic [7:0] page;
    logic [7:0] addr;
  } spg_decode_type;

  // Stack operation codes
  typedef enum logic [1:0] {
    SPG_OP_NONE,
    SPG_OP_PUSH,
    SPG_OP_POP
  } spg_op_type;

endpackage

//--- spg_decode.sv
module spg_decode (
  // Core access and current page
  input  wire spg_pkg::spg_direct_type req,
  input  wire logic [7:0]              page,
  input  wire logic [127:0]            all_page_map,
  // Decoded target
  output spg_pkg::spg_decode_type      dec
);
  import spg_pkg::*;

  // Split direct addresses between data RAM and paged register space
  always_comb begin
    dec.ram       = req.valid && (req.addr < UPPER_HALF);              // R01
    dec.special_function_register       = req.valid && (req.addr >= UPPER_HALF);             // R01
    dec.addr      = req.addr;
    dec.all_pages = dec.special_function_register && all_page_map[req.addr[6:0]];           // R13
    dec.page      = dec.all_pages ? PAGE_ZERO : page;                  // R02
  end
endmodule

//--- spg_stack.sv
module spg_stack (
  // Current stack and request
  input  wire spg_pkg::spg_stack_type cur,
  input  wire spg_pkg::spg_op_type    op,
  input  wire logic [7:0]             int_page,
  // Next stack after the operation
  output spg_pkg::spg_stack_type      nxt
);
  import spg_pkg::*;

  // Push shifts down and loads new top, pop shifts up with zero fill
  always_comb begin
    case (op)
      SPG_OP_PUSH: begin
        nxt.top = int_page;   // R05 R07
        nxt.mid = cur.top;    // R07
        nxt.bot = cur.mid;    // R07
      end
      SPG_OP_POP: begin
        nxt.top = cur.mid;    // R08
        nxt.mid = cur.bot;    // R09
        nxt.bot = PAGE_ZERO;  // R09
      end
      default: begin
        nxt = cur;
      end
    endcase
  end
endmodule

//--- spg_page_select.sv
// What this block does
// R01: Direct addresses 0x00-0x7F reach data RAM, 0x80-0xFF reach paged registers.
// R02: The register window is paged by an 8-bit page number, 256 pages.
// R03: Only pages zero and fifteen hold registers; page select chooses among them.
// R04: Software writes the page select first, then accesses the register directly.
// R05: On interrupt entry with auto enabled, top loads the interrupt's flag page.
// R06: Stack levels are page select, next-page middle and last-page bottom.
// R07: Entry pushes: middle to bottom, top to middle, new page to top.
// R08: Return from interrupt pops the middle level back into the top.
// R09: Pop moves bottom into middle; an empty bottom supplies zero.
// R10: Software may rewrite middle and bottom; return uses the written value.
// R11: Software writes to stack levels never push or pop.
// R12: Auto page enable bit in page control; reset leaves it set.
// R13: Some registers decode on every page regardless of page select.
// R14: Clearing auto enable stops both auto switching and stack push/pop.
// R15: All three stack levels are readable and writable by software.
// R16: After reset all stack levels hold zero, so access reaches page zero.
//
// The implementer's own choices: the APB register port and the register offsets.
module spg_page_select (
  // Clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Core events
  input  wire logic                    int_entry,
  input  wire logic [7:0]              int_page,
  input  wire logic                    return_from_interrupt_instr,
  // Core direct access
  input  wire spg_pkg::spg_direct_type core_req,
  input  wire logic [127:0]            all_page_map,
  // Decoded access and current state
  output spg_pkg::spg_decode_type      core_dec,
  output logic [7:0]                   page_select_reg,
  output logic                         auto_page_enable
);
  import spg_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  spg_stack_type  stack;
  spg_stack_type  next_stack;
  spg_stack_type  op_stack;
  spg_op_type     op;
  logic           auto_en;
  logic           next_auto_en;
  logic           bot_loaded;
  logic           next_bot_loaded;
  logic           flag_push;
  logic           flag_pop;
  logic           flag_pop_empty;
  logic           next_flag_push;
  logic           next_flag_pop;
  logic           next_flag_pop_empty;
  logic [31:0]    next_prdata;
  logic           next_pslverr;
  logic           next_pready;
  spg_decode_type dec_w;
  spg_decode_type next_dec;
  logic           acc_wr;
  logic           acc_rd;
  logic           hit;
  logic           acc_now;

  // Stack operation chosen only by core events, gated by auto enable
  always_comb begin
    if (auto_en && int_entry) begin           // R14
      op = SPG_OP_PUSH;                        // R05
    end else if (auto_en && return_from_interrupt_instr) begin // R14
      op = SPG_OP_POP;                         // R08
    end else begin
      op = SPG_OP_NONE;                        // R11
    end
  end

  spg_stack u_stack (
    .cur      (stack),
    .op       (op),
    .int_page (int_page),
    .nxt      (op_stack)
  );

  spg_decode u_decode (
    .req          (core_req),
    .page         (stack.top),
    .all_page_map (all_page_map),
    .dec          (dec_w)
  );

  // ***********************************************************
  // APB decode
  // ***********************************************************
  always_comb begin
    // First access edge starts the answer; writes land when pready shows
    acc_now = psel && penable && !pready;
    acc_rd  = acc_now && !pwrite;
    acc_wr  = psel && penable && pwrite && pready;
    hit    = (paddr == ADDR_PAGE_SELECT) || (paddr == ADDR_STACK_MID) ||
             (paddr == ADDR_STACK_BOT) || (paddr == ADDR_PAGE_CTRL) ||
             (paddr == ADDR_STATUS);
  end

  // Next stack, enable and status; core event wins over software write
  always_comb begin
    next_stack          = op_stack;
    next_auto_en        = auto_en;
    next_bot_loaded     = bot_loaded;
    next_flag_push      = flag_push;
    next_flag_pop       = flag_pop;
    next_flag_pop_empty = flag_pop_empty;
    if (op == SPG_OP_PUSH) begin
      next_bot_loaded = 1'b1;                  // R09
    end else if (op == SPG_OP_POP) begin
      next_bot_loaded = 1'b0;                  // R09
    end
    if (acc_wr && op == SPG_OP_NONE) begin
      case (paddr)
        ADDR_PAGE_SELECT: next_stack.top = pwdata[7:0]; // R04 R15
        ADDR_STACK_MID:   next_stack.mid = pwdata[7:0]; // R10 R15
        ADDR_STACK_BOT: begin
          next_stack.bot  = pwdata[7:0];       // R10 R15
          next_bot_loaded = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (acc_wr && paddr == ADDR_PAGE_CTRL) begin
      next_auto_en = pwdata[AUTO_EN_BIT];      // R12
    end
    // Sticky status, write one to clear, event wins
    if (acc_wr && paddr == ADDR_STATUS) begin
      if (pwdata[ST_PUSH_BIT]) next_flag_push = 1'b0;
      if (pwdata[ST_POP_BIT]) next_flag_pop = 1'b0;
      if (pwdata[ST_POP_EMPTY_BIT]) next_flag_pop_empty = 1'b0;
    end
    if (op == SPG_OP_PUSH) next_flag_push = 1'b1;
    if (op == SPG_OP_POP) next_flag_pop = 1'b1;
    if (op == SPG_OP_POP && !bot_loaded) next_flag_pop_empty = 1'b1;
  end

  // APB answer, one wait state
  always_comb begin
    next_pready  = acc_now;
    next_pslverr = acc_now && !hit;
    next_prdata  = WORD_ZERO;
    if (acc_rd) begin
      case (paddr)
        ADDR_PAGE_SELECT: next_prdata[7:0] = stack.top;   // R15
        ADDR_STACK_MID:   next_prdata[7:0] = stack.mid;   // R15
        ADDR_STACK_BOT:   next_prdata[7:0] = stack.bot;   // R15
        ADDR_PAGE_CTRL:   next_prdata[AUTO_EN_BIT] = auto_en;
        ADDR_STATUS: begin
          next_prdata[ST_UPPER_BIT]     = (stack.top == PAGE_FIFTEEN); // R03
          next_prdata[ST_POP_BIT]       = flag_pop;
          next_prdata[ST_PUSH_BIT]      = flag_push;
          next_prdata[ST_POP_EMPTY_BIT] = flag_pop_empty;
        end
        default: next_prdata = WORD_ZERO;
      endcase
    end
    next_dec = dec_w;                          // R01 R13
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack            <= '{PAGE_RESET, PAGE_RESET, PAGE_RESET}; // R16
      auto_en          <= AUTO_EN_RESET;       // R12
      bot_loaded       <= 1'b0;
      flag_push        <= 1'b0;
      flag_pop         <= 1'b0;
      flag_pop_empty   <= 1'b0;
      pready           <= 1'b0;
      prdata           <= WORD_ZERO;
      pslverr          <= 1'b0;
      core_dec         <= '0;
      page_select_reg  <= PAGE_RESET;
      auto_page_enable <= AUTO_EN_RESET;
    end else if (clk_en) begin
      stack            <= next_stack;          // R06
      auto_en          <= next_auto_en;
      bot_loaded       <= next_bot_loaded;
      flag_push        <= next_flag_push;
      flag_pop         <= next_flag_pop;
      flag_pop_empty   <= next_flag_pop_empty;
      pready           <= next_pready;
      prdata           <= next_prdata;
      pslverr          <= next_pslverr;
      core_dec         <= next_dec;
      page_select_reg  <= next_stack.top;
      auto_page_enable <= next_auto_en;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  property p_push;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && auto_en && int_entry) |=>
      (stack.top == $past(int_page) && stack.mid == $past(stack.top) &&
       stack.bot == $past(stack.mid));
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // R07

  property p_pop;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && auto_en && !int_entry && return_from_interrupt_instr) |=>
      (stack.top == $past(stack.mid) && stack.mid == $past(stack.bot) &&
       stack.bot == PAGE_ZERO);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong"); // R08

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !auto_en && !(acc_wr)) |=> $stable(stack);
  endproperty
  a_disabled: assert property (p_disabled) else $error("stack moved"); // R14

  property p_sw_mid;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc_wr && paddr == ADDR_STACK_MID && op == SPG_OP_NONE) |=>
      (stack.mid == $past(pwdata[7:0]) && stack.top == $past(stack.top));
  endproperty
  a_sw_mid: assert property (p_sw_mid) else $error("mid write"); // R11

  property p_page_out;
    @(posedge pclk) disable iff (!presetn)
    page_select_reg == stack.top;
  endproperty
  a_page_out: assert property (p_page_out) else $error("page out"); // R06

  property p_ram;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && core_req.valid && core_req.addr < UPPER_HALF) |=>
      (core_dec.ram && !core_dec.special_function_register);
  endproperty
  a_ram: assert property (p_ram) else $error("ram decode"); // R01

  property p_sfr_page;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && core_req.valid && core_req.addr >= UPPER_HALF &&
     !all_page_map[core_req.addr[6:0]]) |=>
      (core_dec.special_function_register && core_dec.page == $past(stack.top));
  endproperty
  a_sfr_page: assert property (p_sfr_page) else $error("page decode"); // R02

  property p_all;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && core_req.valid && core_req.addr >= UPPER_HALF &&
     all_page_map[core_req.addr[6:0]]) |=> core_dec.all_pages;
  endproperty
  a_all: assert property (p_all) else $error("all page"); // R13

  property p_ctrl;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc_wr && paddr == ADDR_PAGE_CTRL) |=>
      auto_page_enable == $past(pwdata[AUTO_EN_BIT]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl write"); // R12

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && !pready) |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer"); // R15

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && pready) |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held"); // R15

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && !pready && !hit) |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error"); // R15

  property p_pop_empty;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && op == SPG_OP_POP && !bot_loaded) |=>
      (flag_pop_empty && stack.mid == PAGE_ZERO);
  endproperty
  a_pop_empty: assert property (p_pop_empty) else $error("empty pop"); // R09

  property p_sw_bot;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc_wr && paddr == ADDR_STACK_BOT && op == SPG_OP_NONE) |=>
      (stack.bot == $past(pwdata[7:0]) && stack.top == $past(stack.top) &&
       stack.mid == $past(stack.mid));
  endproperty
  a_sw_bot: assert property (p_sw_bot) else $error("bottom write"); // R10
endmodule

//--- spg_core_model.sv
module spg_core_model (
  // Clock
  input  wire logic               pclk,
  // Core events toward the block
  output logic                    int_entry,
  output logic [7:0]              int_page,
  output logic                    exit_isr,
  // Core direct access
  output spg_pkg::spg_direct_type req
);
  timeunit 1ns;
  timeprecision 1ps;
  import spg_pkg::*;

  // ***********************************************************
  // Idle levels
  // ***********************************************************
  initial begin
    int_entry = 1'b0;
    int_page  = 8'h00;
    exit_isr  = 1'b0;
    req       = '0;
  end

  // ***********************************************************
  // Core actions, each one cycle long
  // ***********************************************************
  // Vector to a service routine with the page of its flag
  task automatic enter(input logic [7:0] pg);
    @(posedge pclk);
    int_entry <= 1'b1;
    int_page  <= pg;
    @(posedge pclk);
    int_entry <= 1'b0;
    int_page  <= ~pg; // Stale page is never shown
  endtask
  // Leave a service routine
  task automatic leave();
    @(posedge pclk);
    exit_isr <= 1'b1;
    @(posedge pclk);
    exit_isr <= 1'b0;
  endtask
  // Direct access after software has picked the page
  task automatic access(input logic [7:0] a);
    @(posedge pclk);
    req <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    req <= '{valid: 1'b0, addr: ~a};
  endtask
endmodule

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spg_pkg::*;

  // ***********************************************************
  // Signals and table
  // ***********************************************************
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } spg_row_type;
  logic           pclk, presetn, clk_en, psel, penable, pwrite;
  logic           pready, pslverr, int_entry, exit_isr, auto_page_enable;
  logic           err;
  logic [7:0]     paddr, int_page, page_select_reg;
  logic [31:0]    pwdata, prdata, rd;
  logic [127:0]   all_page_map;
  spg_direct_type core_req;
  spg_decode_type core_dec;
  int             err_count, total_checks;
  spg_row_type    rows [13] = '{
    '{1'b0, ADDR_PAGE_SELECT, WORD_ZERO, 32'h0, 1'b0},
    '{1'b0, ADDR_STACK_MID, WORD_ZERO, 32'h0, 1'b0},
    '{1'b0, ADDR_STACK_BOT, WORD_ZERO, 32'h0, 1'b0},
    '{1'b0, ADDR_PAGE_CTRL, WORD_ZERO, 32'h1, 1'b0},
    '{1'b1, ADDR_PAGE_SELECT, 32'hffff_ff0f, 32'h0, 1'b0},
    '{1'b0, ADDR_PAGE_SELECT, WORD_ZERO, 32'h0f, 1'b0},
    '{1'b0, ADDR_STATUS, WORD_ZERO, 32'h1, 1'b0},
    '{1'b1, ADDR_STACK_MID, 32'h22, 32'h0, 1'b0},
    '{1'b0, ADDR_STACK_MID, WORD_ZERO, 32'h22, 1'b0},
    '{1'b1, ADDR_STACK_BOT, 32'h33, 32'h0, 1'b0},
    '{1'b0, ADDR_STACK_BOT, WORD_ZERO, 32'h33, 1'b0},
    '{1'b1, 8'h14, 32'h55, 32'h0, 1'b1},
    '{1'b0, 8'h14, WORD_ZERO, 32'h0, 1'b1}};

  // ***********************************************************
  // Design, core model, clock
  // ***********************************************************
  spg_page_select u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .int_entry(int_entry), .int_page(int_page),
    .return_from_interrupt_instr(exit_isr), .core_req(core_req),
    .all_page_map(all_page_map), .core_dec(core_dec),
    .page_select_reg(page_select_reg), .auto_page_enable(auto_page_enable));
  spg_core_model u_cpu (.pclk(pclk), .int_entry(int_entry),
    .int_page(int_page), .exit_isr(exit_isr), .req(core_req));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ***********************************************************
  // Tasks
  // ***********************************************************
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
  // Top from the port, middle over the bus
  task automatic stk(input logic [7:0] t, input logic [7:0] m);
    #1;
    chk(32'(page_select_reg), 32'(t));
    apb(1'b0, ADDR_STACK_MID, WORD_ZERO);
    chk(rd, 32'(m));
  endtask
  // Verdict
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #80000;
    err_count++;
    final_report();
  end

  // ***********************************************************
  // Tests
  // ***********************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en       = 1'b1;
    all_page_map = 128'h2;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd, rows[i].r);
      chk(32'(err), 32'(rows[i].e));
    end
    $display("register table done");
    stk(8'h0f, 8'h22);
    u_cpu.enter(8'h00);
    stk(8'h00, 8'h0f);
    apb(1'b0, ADDR_STACK_BOT, WORD_ZERO);
    chk(rd, 32'h22);
    u_cpu.enter(8'h0f);
    stk(8'h0f, 8'h00);
    u_cpu.leave();
    stk(8'h00, 8'h0f);
    u_cpu.leave();
    stk(8'h0f, 8'h00);
    u_cpu.enter(8'h00);
    apb(1'b1, ADDR_STACK_MID, 32'h07);
    u_cpu.leave();
    stk(8'h07, 8'h00);
    $display("stack done");
    apb(1'b0, ADDR_STATUS, WORD_ZERO);
    chk(rd, 32'he);
    apb(1'b1, ADDR_STATUS, 32'he);
    apb(1'b0, ADDR_STATUS, WORD_ZERO);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_PAGE_CTRL, WORD_ZERO);
    #1;
    chk(32'(auto_page_enable), 32'h0);
    u_cpu.enter(8'h0f);
    stk(8'h07, 8'h00);
    u_cpu.leave();
    stk(8'h07, 8'h00);
    apb(1'b1, ADDR_PAGE_CTRL, 32'h1);
    clk_en <= 1'b0;
    u_cpu.enter(8'h0f);
    #1;
    chk(32'(page_select_reg), 32'h07);
    @(posedge pclk);
    clk_en <= 1'b1;
    $display("enable done");
    u_cpu.access(8'h10);
    #1;
    chk(32'({core_dec.ram, core_dec.special_function_register}), 32'h2);
    u_cpu.access(8'h90);
    #1;
    chk(32'({core_dec.special_function_register, core_dec.all_pages, core_dec.page,
             core_dec.addr}), 32'h20790);
    u_cpu.access(8'h81);
    #1;
    chk(32'({core_dec.special_function_register, core_dec.all_pages, core_dec.page,
             core_dec.addr}), 32'h30081);
    @(posedge pclk);
    all_page_map <= 128'h1_0000;
    u_cpu.access(8'h90);
    #1;
    chk(32'({core_dec.special_function_register, core_dec.all_pages, core_dec.page,
             core_dec.addr}), 32'h30090);
    $display("decode done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'({auto_page_enable, page_select_reg}), 32'h100);
    @(posedge pclk);
    presetn <= 1'b1;
    $display("reset done");
    final_report();
  end
endmodule
